// >>> logic/evps_pkg.sv
// shared constants and types for the exception vector priority select block
package evps_pkg;
    localparam int unsigned NUM_VEC      = 60;           // vectors 0..59
    localparam int unsigned VEC_W        = 6;
    localparam int unsigned NUM_IRQ      = 44;           // interrupt numbers 0..43
    localparam int unsigned PRI_W        = 3;            // programmable priority 0..7
    localparam int unsigned RANK_W       = 4;            // internal rank: fixed ones below 3
    localparam logic [5:0]  IRQ_VEC_BASE = 6'h10;        // vector of interrupt 0
    localparam logic [5:0]  IRQ_RSV_LO   = 6'h27;        // interrupt 39
    localparam logic [5:0]  IRQ_RSV_HI   = 6'h2a;        // interrupt 42
    localparam logic [5:0]  VEC_RESET    = 6'h01;
    localparam logic [5:0]  VEC_NMI      = 6'h02;
    localparam logic [5:0]  VEC_HARD     = 6'h03;
    localparam logic [5:0]  VEC_MEM      = 6'h04;
    localparam logic [5:0]  VEC_BUS      = 6'h05;
    localparam logic [5:0]  VEC_USAGE    = 6'h06;
    localparam logic [5:0]  VEC_SVC      = 6'h0b;
    localparam logic [5:0]  VEC_DEBUG    = 6'h0c;
    localparam logic [5:0]  VEC_PENDABLE_SERVICE_REQUEST   = 6'h0e;
    localparam logic [5:0]  VEC_TICK     = 6'h0f;
    localparam logic [31:0] OFS_BUS_FAULT = 32'h0000_0014;
    localparam logic [31:0] OFS_IRQ0      = 32'h0000_0040;
    // ranks: fixed -3,-2,-1 map to 0,1,2; programmable p maps to p+3
    localparam logic [3:0]  RANK_RESET   = 4'h0;
    localparam logic [3:0]  RANK_NMI     = 4'h1;
    localparam logic [3:0]  RANK_HARD    = 4'h2;
    localparam logic [3:0]  RANK_PROG0   = 4'h3;
    localparam logic [3:0]  RANK_IDLE    = 4'hf;         // thread mode, nothing active
    localparam logic [2:0]  PRI_RESET    = 3'h0;
    localparam logic [31:0] VTB_RESET    = 32'h0000_0000;
    localparam logic [31:0] VTB_MIN      = 32'h0000_0100;
    localparam logic [31:0] VTB_MAX      = 32'h3fff_ff00;
    localparam logic [31:0] VTB_ALIGN    = 32'h0000_00ff;
    typedef enum logic [1:0] {
        EVPS_IDLE   = 2'b00,
        EVPS_OFFER  = 2'b01,
        EVPS_ACTIVE = 2'b10
    } evps_state_t;
endpackage

// >>> logic/evps_arb.sv
// lowest-rank, lowest-number select tree over all pending vectors
`timescale 1ns/1ps
module evps_arb (
    input  wire logic [evps_pkg::NUM_VEC-1:0]                     pend,     // pending per vector
    input  wire logic [evps_pkg::NUM_VEC-1:0][evps_pkg::RANK_W-1:0] rank,   // rank per vector
    output logic                                                  any,      // something pending
    output logic [evps_pkg::VEC_W-1:0]                            win_vec,  // winning vector
    output logic [evps_pkg::RANK_W-1:0]                           win_rank  // its rank
);
    always_comb begin
        any      = 1'b0;
        win_vec  = '0;
        win_rank = evps_pkg::RANK_IDLE;
        // descending scan: a later, lower number wins ties
        for (int i = evps_pkg::NUM_VEC - 1; i >= 0; i--) begin
            if (pend[i] && (!any || rank[i] <= win_rank)) begin
                any      = 1'b1;
                win_vec  = evps_pkg::VEC_W'(i);
                win_rank = rank[i];
            end
        end
    end
endmodule // evps_arb

// >>> logic/evps_top.sv
// exception vectoring, priority arbitration and preemption decision
`timescale 1ns/1ps
module evps_top (
    input  wire logic                              clk,            // 200 MHz system clock
    input  wire logic                              srst,           // synchronous reset, high
    input  wire logic [evps_pkg::NUM_IRQ-1:0]      irq_req,        // peripheral interrupt levels
    input  wire logic [evps_pkg::NUM_IRQ-1:0]      irq_en,         // per-interrupt enable
    input  wire logic                              nmi_req,        // nmi pulse
    input  wire logic                              hard_req,       // hard fault pulse
    input  wire logic                              mem_req,        // memory management fault pulse
    input  wire logic                              bus_req,        // bus fault pulse
    input  wire logic                              bus_imprecise,  // bus fault is imprecise
    input  wire logic                              usage_req,      // usage fault pulse
    input  wire logic                              svc_req,        // supervisor call pulse
    input  wire logic                              debug_req,      // debug monitor pulse
    input  wire logic                              pendable_service_request_req,     // pendable service pulse
    input  wire logic                              tick_req,       // system tick pulse
    input  wire logic                              pri_wr,         // priority write strobe
    input  wire logic [evps_pkg::VEC_W-1:0]        pri_wr_vec,     // vector being written
    input  wire logic [7:0]                        pri_wr_data,    // priority value
    input  wire logic                              vtb_wr,         // table base write strobe
    input  wire logic                              vtb_wr_priv,    // writer is privileged
    input  wire logic [31:0]                       vtb_wr_data,    // new table base
    input  wire logic                              entry_ack,      // core takes offered vector
    input  wire logic                              exc_return,     // core leaves active handler
    output logic                                   exc_req,        // entry or preemption request
    output logic [evps_pkg::VEC_W-1:0]             exc_vec,        // offered vector number
    output logic [31:0]                            exc_fetch_addr, // vector fetch address
    output logic                                   exc_is_fault,   // offered vector is a fault
    output logic                                   exc_is_isr,     // offered vector is an irq
    output logic                                   exc_bus_async,  // offered bus fault imprecise
    output logic [31:0]                            vtb_base,       // current table base
    output logic [evps_pkg::VEC_W-1:0]             active_vec,     // innermost active vector
    output logic [evps_pkg::RANK_W-1:0]            active_rank,    // its rank, idle = 15
    output logic [evps_pkg::NUM_VEC-1:0]           pend_vec        // pending per vector
);
    localparam int unsigned NV = evps_pkg::NUM_VEC;
    localparam int unsigned VW = evps_pkg::VEC_W;

    typedef struct packed {
        evps_pkg::evps_state_t                state;
        logic [31:0]                          vtb;
        logic [NV-1:0][evps_pkg::PRI_W-1:0]   pri;
        logic [NV-1:0]                        pend;
        logic [NV-1:0]                        act;
        logic [NV-1:0][evps_pkg::RANK_W-1:0]  stk_rank;  // rank saved per active vector
        logic                                 bus_async;
        logic [VW-1:0]                        off_vec;
        logic [VW-1:0]                        cur_vec;
        logic [evps_pkg::RANK_W-1:0]          cur_rank;
        logic [31:0]                          fetch;
        logic                                 is_fault;
        logic                                 is_isr;
    } evps_regs_t;

    evps_regs_t st_ff;
    evps_regs_t nxt_st;

    logic [NV-1:0]                       raise;
    logic [NV-1:0]                       valid_vec;
    logic [NV-1:0]                       prog_vec;
    logic [NV-1:0][evps_pkg::RANK_W-1:0] rank;
    logic                                arb_any;
    logic [VW-1:0]                       arb_vec;
    logic [evps_pkg::RANK_W-1:0]         arb_rank;

    // vector map: fixed ones, programmable system ones, and interrupts
    genvar g;
    generate
        for (g = 0; g < NV; g++) begin : g_vec
            localparam logic [VW-1:0] GV = VW'(g);
            if (g < 16) begin : g_sys
                assign valid_vec[g] = (GV == evps_pkg::VEC_NMI) || (GV == evps_pkg::VEC_HARD)
                                   || (GV == evps_pkg::VEC_MEM) || (GV == evps_pkg::VEC_BUS)
                                   || (GV == evps_pkg::VEC_USAGE) || (GV == evps_pkg::VEC_SVC)
                                   || (GV == evps_pkg::VEC_DEBUG) || (GV == evps_pkg::VEC_PENDABLE_SERVICE_REQUEST)
                                   || (GV == evps_pkg::VEC_TICK);
                assign prog_vec[g]  = valid_vec[g] && (GV != evps_pkg::VEC_NMI)
                                   && (GV != evps_pkg::VEC_HARD);
                assign raise[g] = (GV == evps_pkg::VEC_NMI)    ? nmi_req    :
                                  (GV == evps_pkg::VEC_HARD)   ? hard_req   :
                                  (GV == evps_pkg::VEC_MEM)    ? mem_req    :
                                  (GV == evps_pkg::VEC_BUS)    ? bus_req    :
                                  (GV == evps_pkg::VEC_USAGE)  ? usage_req  :
                                  (GV == evps_pkg::VEC_SVC)    ? svc_req    :
                                  (GV == evps_pkg::VEC_DEBUG)  ? debug_req  :
                                  (GV == evps_pkg::VEC_PENDABLE_SERVICE_REQUEST) ? pendable_service_request_req :
                                  (GV == evps_pkg::VEC_TICK)   ? tick_req   : 1'b0;
            end else begin : g_irq
                // interrupt n sits at vector n+16; 39-42 have no source
                assign valid_vec[g] = !((GV - evps_pkg::IRQ_VEC_BASE) >= evps_pkg::IRQ_RSV_LO
                                     && (GV - evps_pkg::IRQ_VEC_BASE) <= evps_pkg::IRQ_RSV_HI);
                assign prog_vec[g]  = valid_vec[g];
                assign raise[g]     = valid_vec[g] && irq_req[g-16] && irq_en[g-16];
            end
            // fixed ranks sit below every programmable one
            assign rank[g] = (GV == evps_pkg::VEC_NMI)  ? evps_pkg::RANK_NMI  :
                             (GV == evps_pkg::VEC_HARD) ? evps_pkg::RANK_HARD :
                             (evps_pkg::RANK_W'(st_ff.pri[g]) + evps_pkg::RANK_PROG0);
        end
    endgenerate

    evps_arb u_arb (
        .pend     (st_ff.pend),
        .rank     (rank),
        .any      (arb_any),
        .win_vec  (arb_vec),
        .win_rank (arb_rank)
    );

    always_comb begin
        logic [VW-1:0]               rv;
        logic [evps_pkg::RANK_W-1:0] rr;
        logic                        found;
        nxt_st = st_ff;
        rv     = '0;
        rr     = evps_pkg::RANK_IDLE;
        found  = 1'b0;

        // new sources latch as pending; equal-rank ones wait here
        nxt_st.pend = st_ff.pend | (raise & valid_vec);
        if (bus_req) begin
            nxt_st.bus_async = bus_imprecise;
        end

        // privileged, aligned, in-range writes only
        if (vtb_wr && vtb_wr_priv && vtb_wr_data >= evps_pkg::VTB_MIN
            && vtb_wr_data <= evps_pkg::VTB_MAX
            && (vtb_wr_data & evps_pkg::VTB_ALIGN) == '0) begin
            nxt_st.vtb = vtb_wr_data;
        end

        // only three bits kept; fixed vectors ignore writes
        if (pri_wr && int'(pri_wr_vec) < NV && prog_vec[pri_wr_vec]) begin
            nxt_st.pri[pri_wr_vec] = pri_wr_data[evps_pkg::PRI_W-1:0];
        end

        case (st_ff.state)
            evps_pkg::EVPS_IDLE, evps_pkg::EVPS_ACTIVE: begin
                // strictly smaller rank preempts; idle rank 15 admits all
                if (arb_any && arb_rank < st_ff.cur_rank) begin
                    nxt_st.state    = evps_pkg::EVPS_OFFER;
                    nxt_st.off_vec  = arb_vec;
                    nxt_st.fetch    = st_ff.vtb + {24'h00_0000, arb_vec, 2'b00};
                    nxt_st.is_fault = (arb_vec == evps_pkg::VEC_HARD)
                                   || (arb_vec == evps_pkg::VEC_MEM)
                                   || (arb_vec == evps_pkg::VEC_BUS)
                                   || (arb_vec == evps_pkg::VEC_USAGE);
                    nxt_st.is_isr   = arb_vec >= evps_pkg::IRQ_VEC_BASE;
                end
            end
            evps_pkg::EVPS_OFFER: begin
                if (entry_ack) begin
                    nxt_st.pend[st_ff.off_vec]     = raise[st_ff.off_vec]; // set wins
                    nxt_st.act[st_ff.off_vec]      = 1'b1;
                    nxt_st.stk_rank[st_ff.off_vec] = st_ff.cur_rank;
                    nxt_st.cur_vec                 = st_ff.off_vec;
                    nxt_st.cur_rank                = rank[st_ff.off_vec];
                    nxt_st.state                   = evps_pkg::EVPS_ACTIVE;
                end else if (arb_rank < rank[st_ff.off_vec]) begin
                    // late arrival re-targets; keep handler state so a return is not lost
                    nxt_st.state = (st_ff.cur_rank == evps_pkg::RANK_IDLE) ? evps_pkg::EVPS_IDLE
                                                                           : evps_pkg::EVPS_ACTIVE;
                end
            end
            default: nxt_st.state = evps_pkg::EVPS_IDLE;
        endcase

        if (exc_return && st_ff.state == evps_pkg::EVPS_ACTIVE) begin
            nxt_st.act[st_ff.cur_vec] = 1'b0;
            nxt_st.cur_rank           = st_ff.stk_rank[st_ff.cur_vec];
            // next innermost: the active vector whose rank was saved
            for (int i = NV - 1; i >= 0; i--) begin
                if (st_ff.act[i] && VW'(i) != st_ff.cur_vec
                    && rank[i] == st_ff.stk_rank[st_ff.cur_vec] && !found) begin
                    rv    = VW'(i);
                    rr    = rank[i];
                    found = 1'b1;
                end
            end
            nxt_st.cur_vec = found ? rv : '0;
            nxt_st.state   = found ? evps_pkg::EVPS_ACTIVE : evps_pkg::EVPS_IDLE;
            if (!found) begin
                nxt_st.cur_rank = rr;
            end
        end

        if (srst) begin
            nxt_st.state     = evps_pkg::EVPS_IDLE;
            nxt_st.vtb       = evps_pkg::VTB_RESET;
            nxt_st.pri       = '0;
            nxt_st.pend      = '0;
            nxt_st.act       = '0;
            nxt_st.stk_rank  = '0;
            nxt_st.bus_async = 1'b0;
            nxt_st.off_vec   = '0;
            nxt_st.cur_vec   = '0;
            nxt_st.cur_rank  = evps_pkg::RANK_IDLE;
            nxt_st.fetch     = '0;
            nxt_st.is_fault  = 1'b0;
            nxt_st.is_isr    = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign exc_req        = st_ff.state == evps_pkg::EVPS_OFFER;
    assign exc_vec        = st_ff.off_vec;
    assign exc_fetch_addr = st_ff.fetch;
    assign exc_is_fault   = st_ff.is_fault;
    assign exc_is_isr     = st_ff.is_isr;
    assign exc_bus_async  = st_ff.bus_async;
    assign vtb_base       = st_ff.vtb;
    assign active_vec     = st_ff.cur_vec;
    assign active_rank    = st_ff.cur_rank;
    assign pend_vec       = st_ff.pend;
endmodule // evps_top

// >>> bench/evps_top_monitor.sv
// concurrent checks on the vector priority select ports
`timescale 1ns/1ps
module evps_top_monitor (
    input wire logic                         clk,            // clock
    input wire logic                         srst,           // sync reset
    input wire logic [evps_pkg::NUM_IRQ-1:0] irq_req,        // irq levels
    input wire logic [evps_pkg::NUM_IRQ-1:0] irq_en,         // irq enables
    input wire logic                         entry_ack,      // core takes offer
    input wire logic                         exc_req,        // offer
    input wire logic [evps_pkg::VEC_W-1:0]   exc_vec,        // offered vector
    input wire logic [31:0]                  exc_fetch_addr, // fetch address
    input wire logic                         exc_is_fault,   // fault class
    input wire logic                         exc_is_isr,     // irq class
    input wire logic [31:0]                  vtb_base,       // table base
    input wire logic [evps_pkg::VEC_W-1:0]   active_vec,     // active vector
    input wire logic [evps_pkg::RANK_W-1:0]  active_rank,    // active rank
    input wire logic [evps_pkg::NUM_VEC-1:0] pend_vec        // pending
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_reset_clear: assert property (disable iff (1'b0) srst |=>
        vtb_base == evps_pkg::VTB_RESET && !exc_req && pend_vec == '0
        && active_rank == evps_pkg::RANK_IDLE) else $error("reset left state behind");
    a_base_legal: assert property (vtb_base[7:0] == 8'h00 && (vtb_base == 32'h0000_0000
        || (vtb_base >= evps_pkg::VTB_MIN && vtb_base <= evps_pkg::VTB_MAX)))
        else $error("table base out of range");
    a_fetch_sum: assert property (exc_req |->
        exc_fetch_addr == vtb_base + {24'h00_0000, exc_vec, 2'b00}) else $error("bad fetch");
    a_isr_class: assert property (exc_req |->
        exc_is_isr == (exc_vec >= evps_pkg::IRQ_VEC_BASE)) else $error("isr class wrong");
    a_fault_class: assert property (exc_req |-> exc_is_fault ==
        (exc_vec inside {[evps_pkg::VEC_HARD:evps_pkg::VEC_USAGE]})) else $error("fault class");
    a_entry_urgent: assert property (exc_req && entry_ack |=>
        active_vec == $past(exc_vec) && active_rank < $past(active_rank))
        else $error("entry not more urgent");
    a_nmi_alone: assert property (active_rank == evps_pkg::RANK_NMI |-> !exc_req)
        else $error("offer while nmi active");
    a_hard_rank: assert property (exc_req && entry_ack && exc_vec == evps_pkg::VEC_HARD |=>
        active_rank == evps_pkg::RANK_HARD) else $error("hard fault rank wrong");
    a_irq_pends: assert property (irq_req[0] && irq_en[0] |=> pend_vec[16])
        else $error("irq 0 not pending on vector 16");
    a_rsv_quiet: assert property (pend_vec[58:55] == 4'h0)
        else $error("reserved vector pending");
endmodule // evps_top_monitor

bind evps_top evps_top_monitor u_mon (.clk(clk), .srst(srst), .irq_req(irq_req),
    .irq_en(irq_en), .entry_ack(entry_ack), .exc_req(exc_req), .exc_vec(exc_vec),
    .exc_fetch_addr(exc_fetch_addr), .exc_is_fault(exc_is_fault), .exc_is_isr(exc_is_isr),
    .vtb_base(vtb_base), .active_vec(active_vec), .active_rank(active_rank),
    .pend_vec(pend_vec));

// >>> bench/evps_core_model.sv
// processor core stand-in: takes offers and leaves handlers on command
`timescale 1ns/1ps
module evps_core_model (
    input  wire logic clk,        // clock
    input  wire logic srst,       // sync reset
    input  wire logic exc_req,    // offer from block
    input  wire logic ack_en,     // low keeps the core slow
    input  wire logic ret_cmd,    // one handler exit
    output logic      entry_ack,  // take offered vector
    output logic      exc_return  // leave innermost handler
);
    logic             en_q;       // ack_en seen at the edge
    logic             ret_q;      // ret_cmd seen at the edge
    logic             rst_q;      // srst seen at the edge
    initial entry_ack = 1'b0;
    initial exc_return = 1'b0;
    // commands taken at the edge, where the bench holds them still; offer read once settled
    always @(posedge clk) begin
        en_q = ack_en;
        ret_q = ret_cmd;
        rst_q = srst;
        #1;
        entry_ack <= exc_req && en_q && !entry_ack && !rst_q;
        exc_return <= ret_q && !rst_q;
    end
endmodule // evps_core_model

// >>> bench/evps_top_bench.sv
// self-checking bench for the vector priority select block
`timescale 1ns/1ps
module evps_top_bench;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [43:0] irq_req, irq_en;
    logic        nmi_req, hard_req, bus_imprecise, pri_wr, vtb_wr, vtb_wr_priv, ack_en;
    logic        ret_cmd, entry_ack, exc_return, exc_req, exc_is_fault, exc_is_isr, bus_async;
    logic [6:0]  sysp;
    logic [5:0]  pri_wr_vec, exc_vec, active_vec;
    logic [7:0]  pri_wr_data;
    logic [31:0] vtb_wr_data, exc_fetch_addr, vtb_base;
    logic [3:0]  active_rank;
    logic [59:0] pend_vec;
    int          mismatches = 0;
    int          n_compared = 0;
    always #2.5 clk = ~clk;
    evps_top dut (.clk(clk), .srst(srst), .irq_req(irq_req), .irq_en(irq_en),
        .nmi_req(nmi_req), .hard_req(hard_req), .mem_req(sysp[6]), .bus_req(sysp[5]),
        .bus_imprecise(bus_imprecise), .usage_req(sysp[4]), .svc_req(sysp[3]),
        .debug_req(sysp[2]), .pendable_service_request_req(sysp[1]), .tick_req(sysp[0]), .pri_wr(pri_wr),
        .pri_wr_vec(pri_wr_vec), .pri_wr_data(pri_wr_data), .vtb_wr(vtb_wr),
        .vtb_wr_priv(vtb_wr_priv), .vtb_wr_data(vtb_wr_data), .entry_ack(entry_ack),
        .exc_return(exc_return), .exc_req(exc_req), .exc_vec(exc_vec),
        .exc_fetch_addr(exc_fetch_addr), .exc_is_fault(exc_is_fault), .exc_is_isr(exc_is_isr),
        .exc_bus_async(bus_async), .vtb_base(vtb_base), .active_vec(active_vec),
        .active_rank(active_rank), .pend_vec(pend_vec));
    evps_core_model core (.clk(clk), .srst(srst), .exc_req(exc_req), .ack_en(ack_en),
        .ret_cmd(ret_cmd), .entry_ack(entry_ack), .exc_return(exc_return));
    task automatic step(int n = 1);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset();
        {irq_req, nmi_req, hard_req, bus_imprecise, pri_wr, vtb_wr, vtb_wr_priv} = '0;
        {ack_en, ret_cmd, sysp, pri_wr_vec, pri_wr_data, vtb_wr_data} = '0;
        irq_en = '1;
        srst = 1'b1;
        step(4);
        srst = 1'b0;
    endtask
    task automatic wr_pri(logic [5:0] v, logic [7:0] d);
        pri_wr = 1'b1;
        pri_wr_vec = v;
        pri_wr_data = d;
        step();
        pri_wr = 1'b0;
        step();
    endtask
    task automatic wait_req();
        for (int i = 0; i < 20 && exc_req !== 1'b1; i++) step();
    endtask
    task automatic wait_act(logic [5:0] v);
        for (int i = 0; i < 20 && active_vec !== v; i++) step();
    endtask
    task automatic pulse(ref logic s, input int gap);
        s = 1'b1;
        step();
        s = 1'b0;
        step(gap);
    endtask
    task automatic t_base();
        logic [31:0] tries [6] = '{32'h0000_0400, 32'h0000_00f0, 32'h0000_0480, 32'h4000_0000,
                                   32'h0000_0100, 32'h3fff_ff00};
        logic        priv [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        logic [31:0] want [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                  32'h0000_0100, 32'h3fff_ff00};
        do_reset();
        chk("vtb_base", 64'(32'h0000_0000), 64'(vtb_base));
        for (int i = 0; i < 6; i++) begin
            vtb_wr = 1'b1;
            vtb_wr_priv = priv[i];
            vtb_wr_data = tries[i];
            step();
            vtb_wr = 1'b0;
            step();
            chk("vtb_base", 64'(want[i]), 64'(vtb_base));
        end
    endtask
    // runs on the relocated base left by t_base
    task automatic t_sys();
        logic [5:0] vt [7] = '{6'h04, 6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0e, 6'h0f};
        bus_imprecise = 1'b1;
        for (int i = 0; i < 7; i++) begin
            sysp = 7'h40 >> i;
            step();
            sysp = '0;
            wait_req();
            chk("exc_vec", 64'(vt[i]), 64'(exc_vec));
            chk("fetch", 64'(32'h3fff_ff00 + {vt[i], 2'b00}), 64'(exc_fetch_addr));
            if (i == 1) chk("bus_async", 64'(1'b1), 64'(bus_async));
            ack_en = 1'b1;
            wait_act(vt[i]);
            ack_en = 1'b0;
            chk("active_rank", 64'(4'h3), 64'(active_rank));
            pulse(ret_cmd, 3);
        end
    endtask
    task automatic t_arb();
        do_reset();
        wr_pri(6'h10, 8'h0a);
        wr_pri(6'h11, 8'h03);
        wr_pri(6'h3b, 8'h02);
        irq_req = 44'h880_0000_0003;
        wait_req();
        chk("exc_vec", 64'(6'h10), 64'(exc_vec));
        chk("fetch", 64'(32'h0000_0040), 64'(exc_fetch_addr));
        chk("pend59", 64'(1'b1), 64'(pend_vec[59]));
        pulse(hard_req, 3);
        chk("exc_vec", 64'(6'h03), 64'(exc_vec));
    endtask
    task automatic t_preempt();
        do_reset();
        wr_pri(6'h10, 8'h05);
        wr_pri(6'h11, 8'h05);
        wr_pri(6'h12, 8'h04);
        ack_en = 1'b1;
        irq_req[0] = 1'b1;
        wait_act(6'h10);
        ack_en = 1'b0;
        irq_req[1] = 1'b1;
        step(4);
        chk("exc_req", 64'(1'b0), 64'(exc_req));
        chk("pend17", 64'(1'b1), 64'(pend_vec[17]));
        irq_req[2] = 1'b1;
        wait_req();
        chk("exc_vec", 64'(6'h12), 64'(exc_vec));
        // drop the level before entry, else it re-pends and re-enters after return
        irq_req[2] = 1'b0;
        ack_en = 1'b1;
        wait_act(6'h12);
        ack_en = 1'b0;
        pulse(ret_cmd, 3);
        chk("active_rank", 64'(4'h8), 64'(active_rank));
        chk("exc_req", 64'(1'b0), 64'(exc_req));
    endtask
    task automatic t_nmi();
        do_reset();
        ack_en = 1'b1;
        pulse(nmi_req, 0);
        wait_act(6'h02);
        ack_en = 1'b0;
        chk("active_rank", 64'(4'h1), 64'(active_rank));
        pulse(hard_req, 4);
        chk("exc_req", 64'(1'b0), 64'(exc_req));
        pulse(ret_cmd, 0);
        wait_req();
        chk("exc_vec", 64'(6'h03), 64'(exc_vec));
        ack_en = 1'b1;
        step(3);
        chk("active_rank", 64'(4'h2), 64'(active_rank));
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        t_base();
        t_sys();
        t_arb();
        t_preempt();
        t_nmi();
        tally_and_finish();
    end
    // whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        mismatches++;
        tally_and_finish();
    end
endmodule // evps_top_bench
